// *** core/hip_pkg.sv ***
`default_nettype none

package hip_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned TC_DIV        = 9;
  localparam logic [3:0]  TC_DIV_LAST   = 4'(TC_DIV - 1);
  localparam logic [15:0] STARTUP_LOAD  = 16'h0100;
  localparam int unsigned STARTUP_CYC   = 256 * TC_DIV;
  localparam logic [15:0] IDLE_CNT_RST  = 16'h0000;

  // ----------------------------------------------------------------
  // idle period select codes and tapped counter bits
  // ----------------------------------------------------------------
  localparam logic [2:0]  SEL_4K        = 3'h0;
  localparam logic [2:0]  SEL_8K        = 3'h1;
  localparam logic [2:0]  SEL_16K       = 3'h2;
  localparam logic [2:0]  SEL_32K       = 3'h3;
  localparam logic [2:0]  SEL_64K       = 3'h4;
  localparam logic [3:0]  TAP_4K        = 4'hB;
  localparam logic [3:0]  TAP_8K        = 4'hC;
  localparam logic [3:0]  TAP_16K       = 4'hD;
  localparam logic [3:0]  TAP_32K       = 4'hE;
  localparam logic [3:0]  TAP_64K       = 4'hF;

  // ----------------------------------------------------------------
  // power states
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    HIP_RUN      = 2'h0,
    HIP_HALT     = 2'h1,
    HIP_OSC_WAIT = 2'h3,
    HIP_IDLE     = 2'h2
  } hip_state_e;

  // unknown codes fall back to the shortest period
  function automatic logic [3:0] hip_tap(input logic [2:0] sel);
    logic [3:0] tap;
    tap = TAP_4K;
    unique case (sel)
      SEL_8K:  tap = TAP_8K;
      SEL_16K: tap = TAP_16K;
      SEL_32K: tap = TAP_32K;
      SEL_64K: tap = TAP_64K;
      default: tap = TAP_4K;
    endcase
    return tap;
  endfunction : hip_tap

  function automatic logic hip_wake_hit(input logic [7:0] en, input logic [7:0] pnd);
    return |(en & pnd);
  endfunction : hip_wake_hit

endpackage : hip_pkg

`default_nettype wire

// *** core/hip_tmr_if.sv ***
`default_nettype none

interface hip_tmr_if;
  logic       osc_on;
  logic       count_on;
  logic       starting;
  logic       load_start;
  logic [2:0] sel;
  logic       period_hit;
  logic       start_done;

  modport ctrl (output osc_on, count_on, starting, load_start, sel, input period_hit, start_done);
  modport tmr  (input osc_on, count_on, starting, load_start, sel, output period_hit, start_done);
endinterface : hip_tmr_if

`default_nettype wire

// *** core/hip_idle_timer.sv ***
`default_nettype none

module hip_idle_timer
  import hip_pkg::*;
(
  input  wire logic mclk,   // oscillator clock
  input  wire logic rst_n,  // sync reset
  hip_tmr_if.tmr    tif     // control side
);

  logic [3:0]  div;
  logic [15:0] cnt;
  logic [15:0] cnt_inc;
  logic [3:0]  tap;
  logic        tick;

  assign tick    = tif.osc_on && (div == TC_DIV_LAST);
  assign cnt_inc = cnt + 16'h0001;
  assign tap     = hip_tap(tif.sel);

  // ----------------------------------------------------------------
  // instruction clock divider
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      div <= 4'h0;
    else if (!tif.osc_on)
      div <= div;
    else if (div == TC_DIV_LAST)
      div <= 4'h0;
    else
      div <= div + 4'h1;
  end

  // ----------------------------------------------------------------
  // counter: startup countdown or free run
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cnt <= IDLE_CNT_RST;
    else if (tif.load_start)
      cnt <= STARTUP_LOAD;
    else if (tick && tif.starting)
      cnt <= cnt - 16'h0001;
    else if (tick && tif.count_on)
      cnt <= cnt_inc;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tif.period_hit <= 1'b0;
      tif.start_done <= 1'b0;
    end
    else
    begin
      tif.period_hit <= tick && tif.count_on && !tif.starting && !tif.load_start
                        && (cnt_inc[tap] != cnt[tap]);
      tif.start_done <= tick && tif.starting && !tif.load_start && (cnt == 16'h0001);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_tc_spacing;
    @(posedge mclk) disable iff (!rst_n)
    tick |=> (!tick) [*8];
  endproperty
  a_tc_spacing: assert property (p_tc_spacing) else $error("instruction tick spacing below nine");

  property p_tc_period;
    @(posedge mclk) disable iff (!rst_n)
    tick ##1 tif.osc_on [*8] ##1 tif.osc_on |-> tick;
  endproperty
  a_tc_period: assert property (p_tc_period) else $error("instruction tick missing after nine");

endmodule : hip_idle_timer

`default_nettype wire

// *** core/hip_ctrl.sv ***
`default_nettype none

module hip_ctrl
  import hip_pkg::*;
(
  input  wire logic       mclk,                  // oscillator clock, 100 MHz
  input  wire logic       rst_n,                 // reset pin, sync, active low
  input  wire logic       osc_is_crystal,        // crystal or resonator selected
  input  wire logic       halt_disable,          // option bit: halt disabled
  input  wire logic       halt_req_wr,           // core writes one to halt flag
  input  wire logic       idle_req_wr,           // core writes one to idle flag
  input  wire logic [2:0] idle_period_sel_reg,   // idle period code
  input  wire logic       idle_timer_irq_enable, // idle timer interrupt enable
  input  wire logic       pend_clear,            // core clears pending bit
  input  wire logic [7:0] wake_en,               // port wake-up enables
  input  wire logic [7:0] wake_pnd,              // port wake-up pending bits
  input  wire logic       clock_monitor_en,      // clock monitor enabled
  input  wire logic       clock_monitor_fault,   // monitor sees a slow clock
  output logic            halt_request_bit,      // halt flag readback
  output logic            idle_request_bit,      // idle flag readback
  output logic            cpu_clk_en,            // core clock gate
  output logic            periph_clk_en,         // timers and peripherals gate
  output logic            osc_enable,            // oscillator running
  output logic            wdog_detect_en,        // watchdog detector active
  output logic            watchdog_output_pin,   // low on clock monitor error
  output logic            idle_timer_pending,    // pending bit
  output logic            idle_timer_irq,        // interrupt request
  output logic            wake_resume,           // pulse: continue after entry point
  output logic            resume_service         // pulse: idle left into service routine
);

  hip_tmr_if  tif ();
  hip_state_e state;
  hip_state_e next_state;
  logic       wake_hit;
  logic       halt_ok;
  logic       next_pending;

  hip_idle_timer u_timer
  (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tif   (tif)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  assign wake_hit = hip_wake_hit(wake_en, wake_pnd);
  assign halt_ok  = halt_req_wr && !halt_disable && !wake_hit;

  always_comb
  begin
    next_state = state;
    unique case (state)
      HIP_RUN:
      begin
        if (halt_ok)
          next_state = HIP_HALT;
        else if (idle_req_wr)
          next_state = HIP_IDLE;
      end
      HIP_HALT:
      begin
        if (wake_hit)
          next_state = osc_is_crystal ? HIP_OSC_WAIT : HIP_RUN;
      end
      HIP_OSC_WAIT:
      begin
        if (tif.start_done)
          next_state = HIP_RUN;
      end
      HIP_IDLE:
      begin
        if (wake_hit || tif.period_hit)
          next_state = HIP_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      state <= HIP_RUN;
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // timer control
  // ----------------------------------------------------------------
  // halt freezes the counter too; it keeps its value unless a crystal wake reloads STARTUP_LOAD
  assign tif.osc_on   = (state != HIP_HALT);
  assign tif.count_on = (state == HIP_RUN) || (state == HIP_IDLE);
  assign tif.starting = (state == HIP_OSC_WAIT);
  assign tif.sel      = idle_period_sel_reg;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      tif.load_start <= 1'b0;
    else
      tif.load_start <= (state == HIP_HALT) && (next_state == HIP_OSC_WAIT);
  end

  // ----------------------------------------------------------------
  // pending and interrupt
  // ----------------------------------------------------------------
  // a toggle in the clearing cycle is kept: set beats clear
  assign next_pending = tif.period_hit || (idle_timer_pending && !pend_clear);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      idle_timer_pending <= 1'b0;
      idle_timer_irq     <= 1'b0;
    end
    else
    begin
      idle_timer_pending <= next_pending;
      idle_timer_irq     <= next_pending && idle_timer_irq_enable;
    end
  end

  // ----------------------------------------------------------------
  // flags and clock gates
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      halt_request_bit <= 1'b0;
      idle_request_bit <= 1'b0;
      cpu_clk_en       <= 1'b1;
      periph_clk_en    <= 1'b1;
      osc_enable       <= 1'b1;
      wdog_detect_en   <= 1'b1;
    end
    else
    begin
      halt_request_bit <= (next_state == HIP_HALT) || (next_state == HIP_OSC_WAIT);
      idle_request_bit <= (next_state == HIP_IDLE);
      cpu_clk_en       <= (next_state == HIP_RUN);
      periph_clk_en    <= (next_state == HIP_RUN);
      osc_enable       <= (next_state != HIP_HALT);
      wdog_detect_en   <= (next_state != HIP_HALT);
    end
  end

  // a halted clock counts as a monitor error, so an enabled monitor fires
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      watchdog_output_pin <= 1'b1;
    else
      watchdog_output_pin <= !(clock_monitor_en && (clock_monitor_fault || next_state == HIP_HALT));
  end

  // ----------------------------------------------------------------
  // resume indications
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wake_resume    <= 1'b0;
      resume_service <= 1'b0;
    end
    else
    begin
      wake_resume    <= (state != HIP_RUN) && (next_state == HIP_RUN);
      resume_service <= (state == HIP_IDLE) && (next_state == HIP_RUN)
                        && next_pending && idle_timer_irq_enable;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic [12:0] wait_cyc;

  always_ff @(posedge mclk)
  begin
    if (!rst_n || state != HIP_OSC_WAIT)
      wait_cyc <= 13'h0000;
    else
      wait_cyc <= wait_cyc + 13'h0001;
  end

  property p_idle_entry;
    (state == HIP_RUN) && idle_req_wr && !halt_ok
    |=> idle_request_bit && osc_enable && wdog_detect_en && !cpu_clk_en;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle entry wrong");

  property p_halt_entry;
    (state == HIP_RUN) && halt_ok |=> halt_request_bit && !osc_enable && !cpu_clk_en;
  endproperty
  a_halt_entry: assert property (p_halt_entry) else $error("halt entry wrong");

  property p_idle_hold;
    (state == HIP_IDLE) [*2] |-> !cpu_clk_en && !periph_clk_en && osc_enable;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle gates wrong");

  property p_halt_wdog;
    (state == HIP_HALT) ##1 (state == HIP_HALT)
    |-> !wdog_detect_en && (watchdog_output_pin == !clock_monitor_en);
  endproperty
  a_halt_wdog: assert property (p_halt_wdog) else $error("halt watchdog wrong");

  property p_port_wake;
    (state == HIP_HALT) && wake_hit && !osc_is_crystal
    |=> cpu_clk_en && wake_resume && !halt_request_bit;
  endproperty
  a_port_wake: assert property (p_port_wake) else $error("halt port wake wrong");

  property p_osc_wait;
    // first counted tick lands one to nine cycles in, set by the frozen divider phase
    (state == HIP_OSC_WAIT) && tif.start_done
    |-> (wait_cyc >= STARTUP_CYC - TC_DIV + 2) && (wait_cyc <= STARTUP_CYC + 1);
  endproperty
  a_osc_wait: assert property (p_osc_wait) else $error("startup delay wrong");

  property p_halt_disabled;
    (state == HIP_RUN) && halt_req_wr && halt_disable |=> !halt_request_bit ##1 !halt_request_bit;
  endproperty
  a_halt_disabled: assert property (p_halt_disabled) else $error("halt taken though disabled");

  property p_pend_set;
    tif.period_hit |=> idle_timer_pending;
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("pending not set");

  property p_irq_gate;
    !idle_timer_irq_enable |=> !idle_timer_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");

  property p_idle_wake;
    (state == HIP_IDLE) && tif.period_hit
    |=> cpu_clk_en && wake_resume && !idle_request_bit && (resume_service == $past(idle_timer_irq_enable));
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle timer wake wrong");

  property p_halt_refused;
    (state == HIP_RUN) && halt_req_wr && wake_hit |=> (state != HIP_HALT) && !halt_request_bit;
  endproperty
  a_halt_refused: assert property (p_halt_refused) else $error("halt taken with wake pending");

  c_crystal_wake: cover property ((state == HIP_OSC_WAIT) ##1 (state == HIP_RUN));
  c_idle_isr:     cover property ((state == HIP_IDLE) ##1 resume_service);
  c_idle_port:    cover property ((state == HIP_IDLE) && wake_hit ##1 (state == HIP_RUN));
  c_halt_refuse:  cover property ((state == HIP_RUN) && halt_req_wr && wake_hit);

endmodule : hip_ctrl

`default_nettype wire

// *** tb/hip_wake_model.sv ***
`default_nettype none

module hip_wake_model
  import hip_pkg::*;
(
  input  wire logic       mclk,  // oscillator clock
  input  wire logic       rst_n, // sync reset
  input  wire logic       fire,  // trigger edge seen on a port line
  input  wire logic [2:0] idx,   // which port line fired
  input  wire logic       clr,   // software clears all pending bits
  output logic      [7:0] pnd    // pending bits towards the controller
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // pending latch
  // ----------------------------------------------------------------
  // sticky until software clears, so a stale bit blocks the next halt
  always_ff @(posedge mclk)
  begin
    if (!rst_n || clr)
      pnd <= 8'h00;
    else if (fire)
      pnd <= pnd | (8'h01 << idx);
  end
endmodule : hip_wake_model

`default_nettype wire

// *** tb/test_halt_idle_power_save_ctrl.sv ***
`default_nettype none

module test_halt_idle_power_save_ctrl
  import hip_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {logic svc; logic use_pnd; logic pnd;} hip_note_s;

  logic mclk = 1'b0, rst_n = 1'b0, osc_is_crystal = 1'b0, halt_disable = 1'b0;
  logic halt_req_wr = 1'b0, idle_req_wr = 1'b0, irq_en = 1'b0, pend_clear = 1'b0;
  logic clock_monitor_en = 1'b0, clock_monitor_fault = 1'b0, wk_fire = 1'b0, wk_clr = 1'b0;
  logic [2:0] sel = 3'h0, wk_idx = 3'h0;
  logic [7:0] wake_en = 8'h00, wake_pnd;
  logic halt_request_bit, idle_request_bit, cpu_clk_en, periph_clk_en, osc_enable;
  logic wdog_detect_en, watchdog_output_pin, idle_timer_pending, idle_timer_irq;
  logic wake_resume, resume_service;
  hip_note_s notes[$];
  hip_note_s nt;
  int miscompares = 0;
  int checked = 0;
  int n;

  always #5 mclk = ~mclk;

  hip_wake_model i_wake (.mclk(mclk), .rst_n(rst_n), .fire(wk_fire), .idx(wk_idx), .clr(wk_clr), .pnd(wake_pnd));

  hip_ctrl i_dut (
    .mclk(mclk), .rst_n(rst_n), .osc_is_crystal(osc_is_crystal), .halt_disable(halt_disable),
    .halt_req_wr(halt_req_wr), .idle_req_wr(idle_req_wr), .idle_period_sel_reg(sel),
    .idle_timer_irq_enable(irq_en), .pend_clear(pend_clear), .wake_en(wake_en), .wake_pnd(wake_pnd),
    .clock_monitor_en(clock_monitor_en), .clock_monitor_fault(clock_monitor_fault),
    .halt_request_bit(halt_request_bit), .idle_request_bit(idle_request_bit), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .osc_enable(osc_enable), .wdog_detect_en(wdog_detect_en),
    .watchdog_output_pin(watchdog_output_pin), .idle_timer_pending(idle_timer_pending),
    .idle_timer_irq(idle_timer_irq), .wake_resume(wake_resume), .resume_service(resume_service));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : tick

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // request pulse for one cycle, with no quiet cycles after it
  task automatic request(input logic halt);
    halt_req_wr = halt;
    idle_req_wr = !halt;
    tick(1);
    halt_req_wr = 1'b0;
    idle_req_wr = 1'b0;
  endtask : request

  task automatic port_wake();
    wk_idx = 3'($urandom_range(0, 7));
    wake_en = 8'h01 << wk_idx;
    tick($urandom_range(3, 12));
    wk_fire = 1'b1;
    tick(1);
    wk_fire = 1'b0;
  endtask : port_wake

  task automatic clear_pnd();
    wk_clr = 1'b1;
    pend_clear = 1'b1;
    tick(1);
    wk_clr = 1'b0;
    pend_clear = 1'b0;
    tick(1);
  endtask : clear_pnd

  task automatic wait_resume(input int lim);
    n = 0;
    while (wake_resume !== 1'b1 && n < lim)
    begin
      tick(1);
      n++;
    end
    check("wake within bound", 1'(n < lim), 1'b1);
    tick(1);
  endtask : wait_resume

  // ----------------------------------------------------------------
  // result monitor
  // ----------------------------------------------------------------
  always
  begin
    @(posedge mclk);
    #2;
    if (wake_resume === 1'b1)
    begin
      if (notes.size() == 0)
        check("note queue", 1'b0, 1'b1);
      else
      begin
        nt = notes.pop_front();
        check("resume_service", resume_service, nt.svc);
        if (nt.use_pnd)
          check("idle_timer_pending", idle_timer_pending, nt.pnd);
        check("flags and clock at resume", {halt_request_bit, idle_request_bit, cpu_clk_en}, 3'b001);
      end
    end
  end

  initial
  begin
    repeat (100000) @(posedge mclk);
    miscompares++;
    conclude();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h00691611));
    tick(6);
    rst_n = 1'b1;
    tick(1);
    check("reset outputs", {cpu_clk_en, periph_clk_en, osc_enable, wdog_detect_en, watchdog_output_pin,
          halt_request_bit, idle_request_bit, idle_timer_pending}, 8'hF8);
    $display("test reset done");

    halt_disable = 1'b1;
    request(1'b1);
    check("halt with option set", {halt_request_bit, cpu_clk_en}, 2'b01);
    halt_disable = 1'b0;
    port_wake();
    tick(1);
    request(1'b1);
    check("halt with wake pending", {halt_request_bit, cpu_clk_en}, 2'b01);
    clear_pnd();
    $display("test halt refusal done");

    clock_monitor_en = 1'b1;
    notes.push_back('{svc: 1'b0, use_pnd: 1'b0, pnd: 1'b0});
    request(1'b1);
    check("halt entry", {halt_request_bit, cpu_clk_en, periph_clk_en, osc_enable, wdog_detect_en,
          watchdog_output_pin}, 6'h20);
    port_wake();
    wait_resume(8);
    check("after halt wake", {osc_enable, wdog_detect_en, watchdog_output_pin}, 3'h7);
    clear_pnd();
    $display("test halt wake done");

    osc_is_crystal = 1'b1;
    clock_monitor_en = 1'b0;
    notes.push_back('{svc: 1'b0, use_pnd: 1'b0, pnd: 1'b0});
    request(1'b1);
    check("pin quiet in halt", watchdog_output_pin, 1'b1);
    port_wake();
    tick(3);
    check("oscillator first", {osc_enable, cpu_clk_en, halt_request_bit}, 3'b101);
    n = 3;
    while (cpu_clk_en !== 1'b1 && n < 3000)
    begin
      tick(1);
      n++;
    end
    check("startup delay", 1'(n >= STARTUP_CYC - TC_DIV && n <= STARTUP_CYC + TC_DIV), 1'b1);
    tick(1);
    clear_pnd();
    osc_is_crystal = 1'b0;
    $display("test crystal wake done");

    sel = ($urandom_range(0, 1) == 0) ? SEL_4K : 3'($urandom_range(5, 7));
    irq_en = 1'b1;
    clear_pnd();
    notes.push_back('{svc: 1'b1, use_pnd: 1'b1, pnd: 1'b1});
    request(1'b0);
    check("idle entry", {idle_request_bit, cpu_clk_en, osc_enable, wdog_detect_en}, 4'hB);
    wait_resume(40000);
    check("irq with enable", idle_timer_irq, 1'b1);
    irq_en = 1'b0;
    tick(2);
    check("irq blocked", idle_timer_irq, 1'b0);
    clear_pnd();
    check("pending cleared", idle_timer_pending, 1'b0);
    $display("test idle timer done");

    notes.push_back('{svc: 1'b0, use_pnd: 1'b0, pnd: 1'b0});
    request(1'b0);
    port_wake();
    wait_resume(8);
    check("idle flag after port wake", idle_request_bit, 1'b0);
    clear_pnd();
    $display("test idle port wake done");

    request(1'b1);
    check("halted before reset", halt_request_bit, 1'b1);
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(1);
    check("reset exit from halt", {halt_request_bit, cpu_clk_en, osc_enable}, 3'b011);
    $display("test halt reset done");

    clock_monitor_en = 1'b1;
    clock_monitor_fault = 1'b1;
    tick(3);
    check("monitor error pin", watchdog_output_pin, 1'b0);
    check("notes left", 16'(notes.size()), 16'h0000);
    $display("test monitor done");
    conclude();
  end
endmodule : test_halt_idle_power_save_ctrl

`default_nettype wire
